// ---- hdl/odt_cfg_regs.vh ----
// register offsets, field positions, reset values for the odt and pattern readout slice
`ifndef ODT_CFG_REGS_VH
`define ODT_CFG_REGS_VH
`define OFF_MODE_REG_THREE      12'h000
`define OFF_TERM_RANK_CONFIG    12'h004
`define OFF_CMD_STATUS          12'h008
`define MR3_WRITE_MASK          32'h0000ffff
`define MR3_RESET               32'h00000000
`define MR3_PATTERN_EN_BIT      2
`define MR3_LOC_LSB             0
`define MR3_LOC_MSB             1
`define MR3_LOC_CALIBRATION     2'h0
`define TRC_WR_LSB              16
`define TRC_RD_LSB              0
`define TRC_RESET               32'h84210000
`define CMD_NONE                2'h0
`define CMD_WRITE               2'h1
`define CMD_READ                2'h2
`endif

// ---- hdl/rank_mask_select.v ----
// selects one four-bit termination mask out of four packed nibbles
module rank_mask_select (
  input  wire [15:0] masks,
  input  wire [1:0]  rank,
  output wire [3:0]  mask
);
  // nibble n holds the mask for rank n
  assign mask = masks[rank*4 +: 4];
endmodule

// ---- hdl/odt_rank_and_pattern_readout.v ----
// odt rank configuration and pattern readout enable, apb register slice
// Summary of operation
// - pattern readout enable bit two routes read data from pattern, else array
// - write to rank n drives odt per write mask n, lsb rank 0
// - read to rank n drives odt per read mask n, lsb rank 0
// - write masks rank 3..0 sit at bits 31-28 down to 19-16
// - read masks rank 3..0 sit at bits 15-12 down to 3-0
// - write masks reset to 8,4,2,1: only target rank terminates
// - read masks reset to zero: no termination on reads
//
// Design decisions made here: the APB slave port and the placing of the registers.
`include "odt_cfg_regs.vh"
module odt_rank_and_pattern_readout (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output wire        pready,
  output wire        pslverr,
  output reg  [31:0] prdata,
  input  wire        cmd_valid,
  input  wire [1:0]  cmd_kind,
  input  wire [1:0]  cmd_rank,
  output reg  [3:0]  odt,
  output reg         pattern_readout_enable,
  output reg  [1:0]  pattern_location_select,
  input  wire [31:0] array_rdata,
  input  wire [31:0] pattern_rdata,
  output reg  [31:0] read_data
);

  // limitations worth knowing:
  // - a mask write and a command in the same cycle: the command uses the old mask
  // - the location field stores any value; keeping it at 00 is up to software
  // - reserved mode bits 15-3 store as written, bits 31-16 have no storage
  // - odt holds its last pattern until the next command, it never times out

  // reset images of the two registers, sliced into fields below
  localparam [31:0] MODE_RESET_WORD = `MR3_RESET;
  localparam [31:0] TRC_RESET_WORD  = `TRC_RESET;
  localparam [31:0] MODE_KEEP_WORD  = `MR3_WRITE_MASK;
  localparam [3:0]  ODT_OFF         = 4'h0;
  localparam [31:0] READ_ZERO       = 32'h00000000;

  // register images as software reads them
  wire [31:0] mode_reg_three;
  wire [31:0] termination_rank_config;
  wire [31:0] cmd_status;
  wire [31:0] mode_write_value;

  // stored mode fields; bits 31-16 own no flops and read as zero
  reg  [12:0] mode_reserved;
  reg         mode_pattern_enable;
  reg  [1:0]  mode_location;
  reg  [12:0] next_mode_reserved;
  reg         next_mode_pattern_enable;
  reg  [1:0]  next_mode_location;

  // one nibble per target rank and command kind
  reg  [3:0]  write_term_mask_rank_zero;
  reg  [3:0]  write_term_mask_rank_one;
  reg  [3:0]  write_term_mask_rank_two;
  reg  [3:0]  write_term_mask_rank_three;
  reg  [3:0]  read_term_mask_rank_zero;
  reg  [3:0]  read_term_mask_rank_one;
  reg  [3:0]  read_term_mask_rank_two;
  reg  [3:0]  read_term_mask_rank_three;
  reg  [31:0] next_termination_rank_config;

  // read path, command tracking and odt
  reg  [31:0] next_prdata;
  reg  [31:0] next_read_data;
  reg  [3:0]  next_odt;
  reg  [1:0]  last_kind;
  reg  [1:0]  last_rank;
  reg  [1:0]  next_last_kind;
  reg  [1:0]  next_last_rank;
  wire [3:0]  wr_mask;
  wire [3:0]  rd_mask;

  // bus decode
  wire        setup_phase;
  wire        access_phase;
  wire        wr_access;
  wire        rd_setup;
  wire        hit_mode;
  wire        hit_trc;
  wire        hit_status;
  wire        addr_hit;
  wire        wr_mode;
  wire        wr_trc;

  // apb decode: zero wait state, so every access phase is also the last one
  assign setup_phase  = psel & ~penable;
  assign access_phase = psel & penable;
  assign wr_access    = access_phase & pwrite;
  assign rd_setup     = setup_phase & ~pwrite;
  assign hit_mode     = (paddr == `OFF_MODE_REG_THREE);
  assign hit_trc      = (paddr == `OFF_TERM_RANK_CONFIG);
  assign hit_status   = (paddr == `OFF_CMD_STATUS);
  assign addr_hit     = hit_mode | hit_trc | hit_status;
  assign wr_mode      = wr_access & hit_mode;
  assign wr_trc       = wr_access & hit_trc;

  // no slave stalls: pready is a constant high
  assign pready  = 1'b1;
  // unmapped addresses answer an error and neither store nor return data
  assign pslverr = access_phase & ~addr_hit;

  // reserved upper half is dropped before it reaches any flop
  assign mode_write_value = pwdata & MODE_KEEP_WORD;

  // next mode fields: a write replaces all stored bits at once
  always @* begin
    next_mode_reserved       = mode_reserved;
    next_mode_pattern_enable = mode_pattern_enable;
    next_mode_location       = mode_location;
    if (wr_mode) begin
      next_mode_reserved       = mode_write_value[15:3];
      next_mode_pattern_enable = mode_write_value[`MR3_PATTERN_EN_BIT];
      next_mode_location       = mode_write_value[`MR3_LOC_MSB:`MR3_LOC_LSB];
    end
  end

  // mode field flops
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_reserved       <= MODE_RESET_WORD[15:3];
      mode_pattern_enable <= MODE_RESET_WORD[`MR3_PATTERN_EN_BIT];
      mode_location       <= MODE_RESET_WORD[`MR3_LOC_MSB:`MR3_LOC_LSB];
    end else begin
      mode_reserved       <= next_mode_reserved;
      mode_pattern_enable <= next_mode_pattern_enable;
      mode_location       <= next_mode_location;
    end
  end

  // software view of the mode register; upper half always zero
  assign mode_reg_three = {16'h0000, mode_reserved, mode_pattern_enable, mode_location};

  // next mask word: a write replaces all eight masks together
  always @* begin
    next_termination_rank_config = termination_rank_config;
    if (wr_trc) begin
      next_termination_rank_config = pwdata;
    end
  end

  // write masks in the upper half, rank n at nibble n
  // reset terminates only the rank being written to
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      write_term_mask_rank_zero  <= TRC_RESET_WORD[`TRC_WR_LSB + 0 +: 4];
      write_term_mask_rank_one   <= TRC_RESET_WORD[`TRC_WR_LSB + 4 +: 4];
      write_term_mask_rank_two   <= TRC_RESET_WORD[`TRC_WR_LSB + 8 +: 4];
      write_term_mask_rank_three <= TRC_RESET_WORD[`TRC_WR_LSB + 12 +: 4];
    end else begin
      write_term_mask_rank_zero  <= next_termination_rank_config[`TRC_WR_LSB + 0 +: 4];
      write_term_mask_rank_one   <= next_termination_rank_config[`TRC_WR_LSB + 4 +: 4];
      write_term_mask_rank_two   <= next_termination_rank_config[`TRC_WR_LSB + 8 +: 4];
      write_term_mask_rank_three <= next_termination_rank_config[`TRC_WR_LSB + 12 +: 4];
    end
  end

  // read masks in the lower half, rank n at nibble n
  // reset leaves every rank unterminated during reads
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      read_term_mask_rank_zero  <= TRC_RESET_WORD[`TRC_RD_LSB + 0 +: 4];
      read_term_mask_rank_one   <= TRC_RESET_WORD[`TRC_RD_LSB + 4 +: 4];
      read_term_mask_rank_two   <= TRC_RESET_WORD[`TRC_RD_LSB + 8 +: 4];
      read_term_mask_rank_three <= TRC_RESET_WORD[`TRC_RD_LSB + 12 +: 4];
    end else begin
      read_term_mask_rank_zero  <= next_termination_rank_config[`TRC_RD_LSB + 0 +: 4];
      read_term_mask_rank_one   <= next_termination_rank_config[`TRC_RD_LSB + 4 +: 4];
      read_term_mask_rank_two   <= next_termination_rank_config[`TRC_RD_LSB + 8 +: 4];
      read_term_mask_rank_three <= next_termination_rank_config[`TRC_RD_LSB + 12 +: 4];
    end
  end

  // packed view; field order follows the rank numbering
  assign termination_rank_config = {write_term_mask_rank_three,
                                    write_term_mask_rank_two,
                                    write_term_mask_rank_one,
                                    write_term_mask_rank_zero,
                                    read_term_mask_rank_three,
                                    read_term_mask_rank_two,
                                    read_term_mask_rank_one,
                                    read_term_mask_rank_zero};

  // status word: last odt pattern, last rank and last command kind
  // read only; a write to it answers without error and stores nothing
  assign cmd_status = {24'h000000, odt, last_rank, last_kind};

  // read data chosen in the setup cycle and held through the access phase
  always @* begin
    next_prdata = prdata;
    if (rd_setup) begin
      case (paddr)
        `OFF_MODE_REG_THREE:   next_prdata = mode_reg_three;
        `OFF_TERM_RANK_CONFIG: next_prdata = termination_rank_config;
        `OFF_CMD_STATUS:       next_prdata = cmd_status;
        default:               next_prdata = READ_ZERO;
      endcase
    end
  end

  // prdata flop; stands until the next read setup cycle
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= READ_ZERO;
    end else begin
      prdata <= next_prdata;
    end
  end

  // registered copies of the mode fields for the sdram side;
  // one cycle behind the register, the read path below uses the stored bit
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pattern_readout_enable  <= MODE_RESET_WORD[`MR3_PATTERN_EN_BIT];
      pattern_location_select <= `MR3_LOC_CALIBRATION;
    end else begin
      pattern_readout_enable  <= mode_pattern_enable;
      pattern_location_select <= mode_location; // stored as written, not checked
    end
  end

  // array or pattern word, chosen by the stored enable bit
  always @* begin
    if (mode_pattern_enable) begin
      next_read_data = pattern_rdata;
    end else begin
      next_read_data = array_rdata;
    end
  end

  // read data flop; the same one cycle of latency for both sources
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      read_data <= READ_ZERO;
    end else begin
      read_data <= next_read_data;
    end
  end

  // write masks in upper half, read masks in lower half
  rank_mask_select u_wr_sel (
    .masks (termination_rank_config[`TRC_WR_LSB +: 16]),
    .rank  (cmd_rank),
    .mask  (wr_mask)
  );
  rank_mask_select u_rd_sel (
    .masks (termination_rank_config[`TRC_RD_LSB +: 16]),
    .rank  (cmd_rank),
    .mask  (rd_mask)
  );

  // next odt: mask of the target rank for reads and writes, off for other kinds, taken when the command is issued
  always @* begin
    next_odt       = odt;
    next_last_kind = last_kind;
    next_last_rank = last_rank;
    if (cmd_valid) begin
      next_last_kind = cmd_kind;
      next_last_rank = cmd_rank;
      case (cmd_kind)
        `CMD_WRITE: next_odt = wr_mask;
        `CMD_READ:  next_odt = rd_mask;
        default:    next_odt = ODT_OFF;
      endcase
    end
  end

  // odt held between commands so a register write cannot glitch a burst
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      odt <= ODT_OFF;
    end else begin
      odt <= next_odt;
    end
  end

  // last command bookkeeping for the status word
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      last_kind <= `CMD_NONE;
      last_rank <= 2'h0;
    end else begin
      last_kind <= next_last_kind;
      last_rank <= next_last_rank;
    end
  end

endmodule

// ---- verif/odt_sva.sv ----
// assertion checker for the odt rank and pattern readout slice
module odt_sva(input wire logic pclk, presetn, psel, penable, pwrite, cmd_valid, pslverr, pattern_readout_enable,
  input wire logic [11:0] paddr, input wire logic [1:0] cmd_kind, cmd_rank, input wire logic [3:0] odt,
  input wire logic [31:0] pwdata, prdata, array_rdata, pattern_rdata, read_data);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] t;
  wire acc = psel && penable;
  wire [3:0] wm = t[16 + 4 * cmd_rank +: 4], rm = t[4 * cmd_rank +: 4];
  // shadow of the mask register; old value wins if a write meets a command
  always @(posedge pclk or negedge presetn)
    if (!presetn) t <= 32'h84210000;
    else if (acc && pwrite && paddr == 12'h004) t <= pwdata;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_write_mask: assert property (cmd_valid && cmd_kind == 2'h1 |=> odt == $past(wm)) else $error("write odt");
  a_read_mask: assert property (cmd_valid && cmd_kind == 2'h2 |=> odt == $past(rm)) else $error("read odt");
  a_none_off: assert property (cmd_valid && cmd_kind[0] == cmd_kind[1] |=> odt == 4'h0) else $error("none odt");
  a_odt_hold: assert property (!cmd_valid |=> $stable(odt)) else $error("odt moved");
  a_data_route: assert property (1 |=> read_data == (pattern_readout_enable ? $past(pattern_rdata) :
    $past(array_rdata))) else $error("route");
  a_enable_copy: assert property (acc && pwrite && paddr == 12'h000 |=> ##1
    pattern_readout_enable == $past(pwdata[2], 2)) else $error("enable");
  a_mask_read: assert property (acc && !pwrite && paddr == 12'h004 |-> prdata == t) else $error("mask");
  a_bad_addr: assert property (acc |-> pslverr == !(paddr == 12'h000 || paddr == 12'h004 || paddr == 12'h008))
    else $error("decode");
endmodule
bind odt_rank_and_pattern_readout odt_sva i_odt_sva(.*);

// ---- verif/sdram_ranks.sv ----
// rank model: array word moves every cycle, pattern word flips with it so stale data shows
module sdram_ranks(input wire logic pclk, output logic [31:0] array_rdata = 32'h0, output wire [31:0] pattern_rdata);
  timeunit 1ns;
  timeprecision 1ps;
  always @(posedge pclk) array_rdata <= array_rdata + 32'h10010011;
  assign pattern_rdata = 32'h5a5a0ff0 ^ {32{array_rdata[0]}};
endmodule

// ---- verif/odt_rank_and_pattern_readout_tb.sv ----
// bench: apb access, odt per command and rank, read data routing
module odt_rank_and_pattern_readout_tb;
  timeunit 1ns / 1ps;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, cmd_valid = 0, pready, pslverr, pattern_readout_enable;
  logic e;
  logic [11:0] paddr = 12'h0;
  logic [1:0] cmd_kind = 2'h0, cmd_rank = 2'h0, pattern_location_select;
  logic [3:0] odt;
  logic [31:0] pwdata = 32'h0, r, d, prdata, array_rdata, pattern_rdata, read_data;
  int error_cnt = 0, n_compared = 0;
  always #12.5 pclk = ~pclk;
  sdram_ranks i_sdram_ranks(.pclk, .array_rdata, .pattern_rdata);
  odt_rank_and_pattern_readout i_odt_rank_and_pattern_readout(.*);
  task chk(input [31:0] g, x);
    n_compared++;
    if (g !== x) $display("[FAIL] %0t got %h want %h", $time, g, x);
    if (g !== x) error_cnt++;
  endtask
  task apb(input w, input [11:0] a, input [31:0] v);
    @(posedge pclk) {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, v};
    @(posedge pclk) penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    {psel, penable} <= 2'b00;
  endtask
  // every kind to every rank; v is the mask word now loaded
  task s_masks(input [31:0] v);
    apb(0, 12'h004, 32'h0);
    chk(r, v);
    for (int n = 0; n < 4; n++)
      for (int k = 0; k < 4; k++) begin
        @(posedge pclk) {cmd_valid, cmd_kind, cmd_rank} <= {1'b1, k[1:0], n[1:0]};
        @(posedge pclk) cmd_valid <= 0;
        @(posedge pclk) chk(odt, k == 1 ? v[16 + 4 * n +: 4] : k == 2 ? v[4 * n +: 4] : 4'h0);
      end
  endtask
  task s_route(input [31:0] m);
    apb(1, 12'h000, m);
    @(posedge pclk) #1 d = m[2] ? pattern_rdata : array_rdata;
    @(posedge pclk) #1 chk(read_data, d);
    chk({31'h0, pattern_readout_enable}, {31'h0, m[2]});
    chk({30'h0, pattern_location_select}, 32'h0);
    apb(0, 12'h000, 32'h0);
    chk(r, m);
  endtask
  // unmapped access errors and stores nothing; status shows the last command
  task s_errs;
    apb(1, 12'h00c, 32'hffffffff);
    chk({31'h0, e}, 32'h1);
    apb(0, 12'h00c, 32'h0);
    chk(r, 32'h0);
    apb(0, 12'h004, 32'h0);
    chk({31'h0, e}, 32'h0);
    chk(r, 32'h124836c9);
    apb(0, 12'h008, 32'h0);
    chk(r, 32'h0000000f);
  endtask
  task wrap_up;
    $display("errors %0d of %0d compared", error_cnt, n_compared);
    if (error_cnt == 0 && n_compared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1;
    s_masks(32'h84210000);
    apb(1, 12'h004, 32'h124836c9);
    s_masks(32'h124836c9);
    s_route(32'h4);
    s_route(32'h0);
    s_errs;
    wrap_up;
  end
  initial begin
    #100us error_cnt++;
    wrap_up;
  end
endmodule
